// ### core/acs_sequencer.sv
// acquisition channel sequencer: address register, strobes, starts, settling delay, conversion control
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
    parameter int RES_W = acs_pkg::RES_BITS,
    parameter int CH_W  = acs_pkg::CH_BITS
) (
    input  wire logic             clk,
    input  wire logic             rst,
    // register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [31:0]           reg_rdata,
    // pins from the host
    input  wire logic [CH_W-1:0]  chan_addr_in,
    input  wire logic             strobe_a,
    input  wire logic             strobe_b,
    input  wire logic             address_load_select,
    input  wire logic             address_clear_select,
    input  wire logic             conversion_start_rise,
    input  wire logic             conversion_start_fall,
    input  wire logic             lower_bank_enable,
    input  wire logic             upper_bank_enable,
    // analog front end
    input  wire logic             comparator_hi,
    output logic [RES_W-1:0]      dac_code,
    output logic                  sample_hold,
    output logic                  lower_bank_route,
    output logic                  upper_bank_route,
    // pins to the host
    output logic [CH_W-1:0]       selected_channel,
    output logic                  settle_delay_out,
    output logic                  conversion_active_flag,
    output logic [RES_W-1:0]      result_out
);
    localparam int NSYNC = CH_W + 9;
    localparam int P_S_A = CH_W;
    localparam int P_S_B = CH_W + 1;
    localparam int P_LD  = CH_W + 2;
    localparam int P_CLR = CH_W + 3;
    localparam int P_SR  = CH_W + 4;
    localparam int P_SF  = CH_W + 5;
    localparam int P_LO  = CH_W + 6;
    localparam int P_UP  = CH_W + 7;
    localparam int P_CMP = CH_W + 8;

    // ---------------- pin synchronisers and edge history
    wire  [NSYNC-1:0] pins_raw = {comparator_hi, upper_bank_enable, lower_bank_enable,
                                  conversion_start_fall, conversion_start_rise,
                                  address_clear_select, address_load_select,
                                  strobe_b, strobe_a, chan_addr_in};
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    logic [NSYNC-1:0] prev_q;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= pins_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                    prev_q[gi] <= sync_q[gi];
                end
            end
        end
    endgenerate

    // pins clear low: idle-high pins rise once after reset
    wire [NSYNC-1:0] rise = sync_q & ~prev_q;
    wire [NSYNC-1:0] fall = ~sync_q & prev_q;

    // ---------------- software registers
    logic [31:0]                    ctrl_q;
    logic [acs_pkg::BIT_CNT_W-1:0]  bit_trim_q;
    logic [acs_pkg::DLY_CNT_W-1:0]  settle_delay_trim_q;
    logic [31:0]                    rdata_q;

    wire sel_ctrl   = (reg_addr == acs_pkg::REG_CTRL);
    wire sel_trim   = (reg_addr == acs_pkg::REG_TRIM);
    wire sel_status = (reg_addr == acs_pkg::REG_STATUS);
    wire sel_result = (reg_addr == acs_pkg::REG_RESULT);

    wire [acs_pkg::BIT_CNT_W-1:0] wr_bit =
        reg_wdata[acs_pkg::TRIM_BIT_LSB +: acs_pkg::BIT_CNT_W];
    wire [acs_pkg::DLY_CNT_W-1:0] wr_dly =
        reg_wdata[acs_pkg::TRIM_DLY_LSB +: acs_pkg::DLY_CNT_W];

    // trims are clamped into the documented ranges
    wire [acs_pkg::BIT_CNT_W-1:0] bit_clamped =
        (wr_bit < acs_pkg::BIT_CNT_W'(acs_pkg::BIT_CYC_MIN)) ? acs_pkg::BIT_CNT_W'(acs_pkg::BIT_CYC_MIN) :
        (wr_bit > acs_pkg::BIT_CNT_W'(acs_pkg::BIT_CYC_MAX)) ? acs_pkg::BIT_CNT_W'(acs_pkg::BIT_CYC_MAX) :
        wr_bit;
    wire [acs_pkg::DLY_CNT_W-1:0] dly_clamped =
        (wr_dly < acs_pkg::DLY_CNT_W'(acs_pkg::DLY_CYC_MIN)) ? acs_pkg::DLY_CNT_W'(acs_pkg::DLY_CYC_MIN) :
        (wr_dly > acs_pkg::DLY_CNT_W'(acs_pkg::DLY_CYC_MAX)) ? acs_pkg::DLY_CNT_W'(acs_pkg::DLY_CYC_MAX) :
        wr_dly;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q     <= acs_pkg::CTRL_RESET;
            bit_trim_q <= acs_pkg::TRIM_BIT_RESET;
            settle_delay_trim_q <= acs_pkg::TRIM_DLY_RESET;
        end else if (reg_wr) begin
            if (sel_ctrl) begin
                ctrl_q <= reg_wdata & 32'h0000_03ff;
            end
            if (sel_trim) begin
                bit_trim_q <= bit_clamped;
                settle_delay_trim_q <= dly_clamped;
            end
        end
    end

    wire acs_pkg::acs_mode_t mode  = acs_pkg::acs_mode_t'(ctrl_q[acs_pkg::CTRL_MODE_LSB +: 2]);
    wire acs_pkg::acs_code_t code  = acs_pkg::acs_code_t'(ctrl_q[acs_pkg::CTRL_CODE_LSB +: 2]);
    wire                     overlap = ctrl_q[acs_pkg::CTRL_OVERLAP];
    wire                     ones_n  = ctrl_q[acs_pkg::CTRL_ONES_N];
    wire [3:0]               trunc   = ctrl_q[acs_pkg::CTRL_TRUNC_LSB +: 4];
    wire                     seq_mode  = (mode == acs_pkg::ACS_MODE_SEQ_CONT) ||
                                         (mode == acs_pkg::ACS_MODE_SEQ_TRIG);
    wire                     free_run  = (mode == acs_pkg::ACS_MODE_SEQ_CONT);

    // ---------------- conversion engine
    logic             sar_busy;
    logic             sar_done;
    logic [RES_W-1:0] sar_result;
    logic             busy_prev_q;
    logic             start_evt;

    // truncate n gives n-1 bits, but at least one; zero or beyond the word gives all bits
    wire [3:0] nbits_raw = (trunc == 4'h0 || trunc > 4'(RES_W)) ? 4'(RES_W) : (trunc - 4'h1);
    wire [3:0] nbits     = (nbits_raw == 4'h0) ? 4'h1 : nbits_raw;

    // comparator is synced; a trial stands a full bit period
    acs_sar #(
        .WIDTH (RES_W),
        .IDX_W (4),
        .CNT_W (acs_pkg::BIT_CNT_W)
    ) u_sar (
        .clk     (clk),
        .rst     (rst),
        .start   (start_evt),
        .period  (bit_trim_q),
        .nbits   (nbits),
        .comp_hi (sync_q[P_CMP]),
        .busy    (sar_busy),
        .trial   (dac_code),
        .result  (sar_result),
        .done    (sar_done)
    );
    // one bit per bit period from the msb keeps busy proportional to bits

    wire busy_fall = busy_prev_q & ~sar_busy;

    // ---------------- strobe decode
    // free run: busy end steps, delay end starts
    wire s_a_hi = sync_q[P_S_A];
    wire s_b_hi = sync_q[P_S_B];
    wire ext_strobe  = (fall[P_S_A] & s_b_hi) | (fall[P_S_B] & s_a_hi);
    wire auto_strobe = free_run & busy_fall & sync_q[P_SR];
    wire strobe_evt  = ext_strobe | auto_strobe;

    // sequential modes step on a strobe unless clear select is low, which clears
    logic [CH_W-1:0] chan_q;
    logic [CH_W-1:0] pend_addr_q;
    logic            pend_q;

    wire do_incr = sync_q[P_LD] | seq_mode;
    wire [CH_W-1:0] next_addr =
        ~sync_q[P_CLR] ? '0 :
        do_incr        ? chan_q + CH_W'(1) :
                         sync_q[CH_W-1:0];

    // normal sequencing defers an address change until the conversion ends
    wire apply_now  = strobe_evt & (overlap | ~sar_busy);
    wire apply_pend = pend_q & ~sar_busy & ~strobe_evt;
    wire defer      = strobe_evt & ~overlap & sar_busy;

    always_ff @(posedge clk) begin
        if (rst) begin
            chan_q      <= '0;
            pend_addr_q <= '0;
            pend_q      <= 1'b0;
        end else begin
            if (apply_now) begin
                chan_q <= next_addr;
                pend_q <= 1'b0;
            end else if (apply_pend) begin
                chan_q <= pend_addr_q;
                pend_q <= 1'b0;
            end else if (defer) begin
                pend_addr_q <= next_addr;
                pend_q      <= 1'b1;
            end
        end
    end

    wire addr_applied = apply_now | apply_pend;

    // ---------------- settling delay
    // each applied address, from a strobe or deferred from one, restarts the delay
    logic [acs_pkg::DLY_CNT_W-1:0] dly_cnt_q;
    logic                          dly_out_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            dly_cnt_q <= '0;
            dly_out_q <= 1'b0;
        end else if (addr_applied) begin
            dly_cnt_q <= settle_delay_trim_q - acs_pkg::DLY_CNT_W'(1);
            dly_out_q <= 1'b1;
        end else if (dly_out_q) begin
            if (dly_cnt_q == '0) begin
                dly_out_q <= 1'b0;
            end else begin
                dly_cnt_q <= dly_cnt_q - acs_pkg::DLY_CNT_W'(1);
            end
        end
    end

    wire dly_fall = dly_out_q & (dly_cnt_q == '0) & ~addr_applied;

    // ---------------- conversion starts
    wire sr_hi      = sync_q[P_SR];
    wire sf_hi      = sync_q[P_SF];
    wire start_rise = rise[P_SR] & ~sf_hi;
    wire start_fall = fall[P_SF] & sr_hi;
    wire auto_start = free_run & dly_fall & sr_hi;
    assign start_evt = start_rise | start_fall | auto_start;

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_prev_q <= 1'b0;
        end else begin
            busy_prev_q <= sar_busy;
        end
    end

    // ---------------- output coding
    wire [RES_W-1:0] twos_code = sar_result ^ {1'b1, {(RES_W-1){1'b0}}};
    // negative offset codes: two's less one
    wire [RES_W-1:0] ones_code = sar_result[RES_W-1] ? twos_code : (twos_code - RES_W'(1));
    logic [RES_W-1:0] coded;

    always_comb begin
        if (!ones_n) begin
            coded = ones_code;
        end else begin
            case (code)
                acs_pkg::ACS_CODE_TWOS:   coded = twos_code;
                acs_pkg::ACS_CODE_OFFSET: coded = sar_result;
                acs_pkg::ACS_CODE_BINARY: coded = sar_result;
                default:                  coded = sar_result;
            endcase
        end
    end

    // result lands a clock after busy falls
    logic [RES_W-1:0] result_q;
    logic             lo_route_q;
    logic             up_route_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            result_q   <= '0;
            lo_route_q <= 1'b0;
            up_route_q <= 1'b0;
        end else begin
            if (sar_done) begin
                result_q <= coded;
            end
            lo_route_q <= sync_q[P_LO] & ~chan_q[CH_W-1];
            up_route_q <= sync_q[P_UP] &  chan_q[CH_W-1];
        end
    end

    // ---------------- register read
    wire [31:0] status_word = {25'h0, pend_q, dly_out_q, sar_busy, chan_q};
    wire [31:0] ctrl_word   = ctrl_q;
    wire [31:0] trim_word   = {4'h0, settle_delay_trim_q, 8'h00, bit_trim_q};
    wire [31:0] result_word = {20'h0, result_q};
    wire [31:0] rd_mux      = sel_ctrl   ? ctrl_word   :
                              sel_trim   ? trim_word   :
                              sel_status ? status_word :
                              sel_result ? result_word : 32'h0;
    // zero outside the answer cycle
    wire [31:0] rdata_d     = reg_rd ? rd_mux : 32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ---------------- outputs
    assign reg_rdata              = rdata_q;
    assign selected_channel       = chan_q;
    assign settle_delay_out       = dly_out_q;
    assign conversion_active_flag = sar_busy;
    assign sample_hold            = sar_busy;
    assign lower_bank_route       = lo_route_q;
    assign upper_bank_route       = up_route_q;
    assign result_out             = result_q;
endmodule : acs_sequencer
`default_nettype wire

// ### core/acs_pkg.sv
// constants, register map and mode encodings of the acquisition channel sequencer
package acs_pkg;
    localparam int CLK_MHZ      = 100;
    localparam int RES_BITS     = 12;
    localparam int CH_BITS      = 4;

    // bit clock period in ns: nominal and slowest trim
    localparam int BIT_NS_NOM   = 1250;
    localparam int BIT_NS_MAX   = 2080;
    localparam int BIT_CYC_MIN  = (BIT_NS_NOM * CLK_MHZ + 999) / 1000;
    localparam int BIT_CYC_MAX  = (BIT_NS_MAX * CLK_MHZ) / 1000;
    // settling delay in ns: nominal, trim range
    localparam int DLY_NS_NOM   = 5000;
    localparam int DLY_NS_MIN   = 3000;
    localparam int DLY_NS_MAX   = 20000;
    localparam int DLY_CYC_NOM  = (DLY_NS_NOM * CLK_MHZ) / 1000;
    localparam int DLY_CYC_MIN  = (DLY_NS_MIN * CLK_MHZ + 999) / 1000;
    localparam int DLY_CYC_MAX  = (DLY_NS_MAX * CLK_MHZ) / 1000;
    localparam int BIT_CNT_W    = 8;
    localparam int DLY_CNT_W    = 12;

    // register byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TRIM   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0c;

    // control register fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_OVERLAP   = 2;
    localparam int CTRL_CODE_LSB  = 3;
    localparam int CTRL_ONES_N    = 5;
    localparam int CTRL_TRUNC_LSB = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0020;

    // trim register fields
    localparam int TRIM_BIT_LSB   = 0;
    localparam int TRIM_DLY_LSB   = 16;
    localparam logic [BIT_CNT_W-1:0] TRIM_BIT_RESET = BIT_CNT_W'(BIT_CYC_MIN);
    localparam logic [DLY_CNT_W-1:0] TRIM_DLY_RESET = DLY_CNT_W'(DLY_CYC_NOM);

    // status register fields
    localparam int STAT_CH_LSB    = 0;
    localparam int STAT_BUSY      = 4;
    localparam int STAT_DLY       = 5;
    localparam int STAT_PEND      = 6;

    typedef enum logic [1:0] {
        ACS_MODE_RANDOM,
        ACS_MODE_SEQ_CONT,
        ACS_MODE_SEQ_TRIG,
        ACS_MODE_SPARE
    } acs_mode_t;

    typedef enum logic [1:0] {
        ACS_CODE_BINARY,
        ACS_CODE_TWOS,
        ACS_CODE_OFFSET,
        ACS_CODE_SPARE
    } acs_code_t;
endpackage : acs_pkg

// ### core/acs_sar.sv
// successive approximation engine with its own bit clock divider
`timescale 1ns/1ps
`default_nettype none
module acs_sar #(
    parameter int WIDTH = 12,
    parameter int IDX_W = 4,
    parameter int CNT_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] period,
    input  wire logic [IDX_W-1:0] nbits,
    input  wire logic             comp_hi,
    output logic                  busy,
    output logic [WIDTH-1:0]      trial,
    output logic [WIDTH-1:0]      result,
    output logic                  done
);
    logic             busy_q;
    logic [CNT_W-1:0] cnt_q;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] left_q;
    logic [WIDTH-1:0] trial_q;
    logic [WIDTH-1:0] result_q;
    logic             done_q;

    wire              tick      = busy_q && (cnt_q == '0);
    wire              last      = (left_q == IDX_W'(1));
    wire [WIDTH-1:0]  bit_mask  = WIDTH'(1) << idx_q;
    wire [WIDTH-1:0]  decided   = comp_hi ? trial_q : (trial_q & ~bit_mask);
    wire [WIDTH-1:0]  next_try  = decided | (bit_mask >> 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q   <= 1'b0;
            cnt_q    <= '0;
            idx_q    <= '0;
            left_q   <= '0;
            trial_q  <= '0;
            result_q <= '0;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                // a new start restarts any conversion in flight
                busy_q  <= 1'b1;
                cnt_q   <= period - CNT_W'(1);
                idx_q   <= IDX_W'(WIDTH - 1);
                left_q  <= nbits;
                trial_q <= WIDTH'(1) << (WIDTH - 1);
            end else if (tick) begin
                cnt_q <= period - CNT_W'(1);
                if (last) begin
                    busy_q   <= 1'b0;
                    trial_q  <= decided;
                    result_q <= decided;
                    done_q   <= 1'b1;
                end else begin
                    trial_q <= next_try;
                    idx_q   <= idx_q - IDX_W'(1);
                    left_q  <= left_q - IDX_W'(1);
                end
            end else if (busy_q) begin
                cnt_q <= cnt_q - CNT_W'(1);
            end
        end
    end

    assign busy   = busy_q;
    assign trial  = trial_q;
    assign result = result_q;
    assign done   = done_q;
endmodule : acs_sar
`default_nettype wire

// ### tb/acs_front_model.sv
// analog front end model: tracking sample-and-hold feeding the comparator
`timescale 1ns/1ps
`default_nettype none
module acs_front_model (
    input  wire logic        clk,
    input  wire logic [11:0] vin,
    input  wire logic        sample_hold,
    input  wire logic [11:0] dac_code,
    output logic             comparator_hi
);
    logic [11:0] held_q;
    always_ff @(posedge clk) begin
        if (!sample_hold) begin
            held_q <= vin;
        end
    end
    assign comparator_hi = held_q >= dac_code;
endmodule : acs_front_model
`default_nettype wire

// ### tb/acs_sequencer_sva.sv
// port assertions of the acquisition channel sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        conversion_start_rise,
    input wire logic        conversion_start_fall,
    input wire logic        sample_hold,
    input wire logic        lower_bank_route,
    input wire logic        upper_bank_route,
    input wire logic [3:0]  selected_channel,
    input wire logic        settle_delay_out,
    input wire logic        conversion_active_flag,
    input wire logic [11:0] dac_code,
    input wire logic [11:0] result_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [11:0] busy_cnt_q;
    logic [11:0] dly_cnt_q;
    // count high cycles of the two timed outputs
    always_ff @(posedge clk) begin
        busy_cnt_q <= (rst || !conversion_active_flag) ? 12'h000 : busy_cnt_q + 12'h001;
        dly_cnt_q  <= (rst || !settle_delay_out) ? 12'h000 : dly_cnt_q + 12'h001;
    end
    a_hold_busy: assert property (sample_hold == conversion_active_flag)
        else $error("hold differs from busy flag");
    a_busy_length: assert property ($fell(conversion_active_flag)
        |-> busy_cnt_q inside {[12'd125:12'd2496]}) else $error("busy length out of range");
    a_settle_length: assert property ($fell(settle_delay_out)
        |-> dly_cnt_q inside {[12'd300:12'd2000]}) else $error("settle length out of range");
    a_route_lower: assert property (lower_bank_route |-> !$past(selected_channel[3]))
        else $error("lower bank routed for upper channel");
    a_route_upper: assert property (upper_bank_route |-> $past(selected_channel[3]))
        else $error("upper bank routed for lower channel");
    a_chan_settle: assert property (!$stable(selected_channel) |-> $rose(settle_delay_out))
        else $error("channel moved without settle start");
    a_result_end: assert property (!$stable(result_out)
        |-> $past(conversion_active_flag, 2) && !$past(conversion_active_flag))
        else $error("result moved outside conversion end");
    a_msb_first: assert property ($rose(conversion_active_flag) |-> dac_code == 12'h800)
        else $error("first trial is not the top bit");
    a_start_rise: assert property ($rose(conversion_start_rise) && !conversion_start_fall
        |-> ##[1:6] conversion_active_flag) else $error("rising start ignored");
    a_start_fall: assert property ($fell(conversion_start_fall) && conversion_start_rise
        |-> ##[1:6] conversion_active_flag) else $error("falling start ignored");
    c_conv_end: cover property ($fell(conversion_active_flag));
    c_settle_end: cover property ($fell(settle_delay_out));
    c_upper_route: cover property (upper_bank_route);
endmodule : acs_sequencer_sva
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the acquisition channel sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, rst, reg_wr, reg_rd, strobe_a, strobe_b, rd_q, flag_q, end_q;
    logic        address_load_select, address_clear_select, conversion_start_rise, conversion_start_fall;
    logic        lower_bank_enable, upper_bank_enable, comparator_hi, sample_hold, lower_bank_route;
    logic        upper_bank_route, settle_delay_out, conversion_active_flag;
    logic [3:0]  chan_addr_in, selected_channel;
    logic [7:0]  reg_addr;
    logic [11:0] dac_code, result_out, vin;
    logic [31:0] reg_wdata, reg_rdata;
    logic [31:0] q_rd[$];
    logic [11:0] q_res[$];
    int          errors = 0;
    int          n_tests = 0;
    integer      seed = 32'hd9f67854;

    acs_sequencer dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chan_addr_in,
        .strobe_a, .strobe_b, .address_load_select, .address_clear_select, .conversion_start_rise,
        .conversion_start_fall, .lower_bank_enable, .upper_bank_enable, .comparator_hi, .dac_code,
        .sample_hold, .lower_bank_route, .upper_bank_route, .selected_channel, .settle_delay_out,
        .conversion_active_flag, .result_out);
    acs_front_model u_front (.clk, .vin, .sample_hold, .dac_code, .comparator_hi);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_res(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t result %h expected %h", $time, got, exp);
        end
    endtask : cmp_res

    function automatic logic [11:0] coded(input int c, input logic [11:0] x);
        case (c)
            1: coded = x ^ 12'h800;
            3: coded = (x ^ 12'h800) - {11'h000, ~x[11]};
            4: coded = x & 12'hf00;
            default: coded = x;
        endcase
    endfunction : coded

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : rd

    // bounded wait until neither settling nor converting
    task automatic wait_quiet;
        int i;
        for (i = 0; i < 4000 && (settle_delay_out !== 1'b0 || conversion_active_flag !== 1'b0); i++) @(posedge clk);
        if (i == 4000) begin
            errors++;
            $display("CHECK FAILED %0t wait ran out", $time);
            conclude();
        end
    endtask : wait_quiet

    task automatic pulse_strobe(input logic sel_b, input logic [3:0] a, input logic ld, input logic clr);
        chan_addr_in <= a;
        address_load_select <= ld;
        address_clear_select <= clr;
        repeat (4) @(posedge clk);
        if (sel_b) begin
            strobe_b <= 1'b0;
        end else begin
            strobe_a <= 1'b0;
        end
        repeat (5) @(posedge clk);
        strobe_a <= 1'b1;
        strobe_b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : pulse_strobe

    task automatic step(input logic sel_b, input logic [3:0] a, input logic ld, input logic clr, input logic [3:0] e);
        pulse_strobe(sel_b, a, ld, clr);
        wait_quiet();
        cmp_reg({28'h0, selected_channel}, {28'h0, e});
        rd(acs_pkg::REG_STATUS, {28'h0, e});
    endtask : step

    // a falling-edge start needs the rising input high first, with no rising start on the way
    task automatic convert(input logic by_fall, input logic [11:0] e);
        q_res.push_back(e);
        if (by_fall) begin
            conversion_start_fall <= 1'b1;
            repeat (4) @(posedge clk);
            conversion_start_rise <= 1'b1;
            repeat (4) @(posedge clk);
            conversion_start_fall <= 1'b0;
        end else begin
            conversion_start_rise <= 1'b1;
        end
        repeat (8) @(posedge clk);
        conversion_start_rise <= 1'b0;
    endtask : convert

    always @(posedge clk) begin : watch
        rd_q <= reg_rd;
        flag_q <= conversion_active_flag;
        end_q <= flag_q && !conversion_active_flag;
        if (rd_q && q_rd.size() > 0) begin
            cmp_reg(reg_rdata, q_rd.pop_front());
        end
        if (end_q && q_res.size() > 0) begin
            cmp_res(result_out, q_res.pop_front());
        end
    end

    initial begin : main
        int i;
        int k;
        logic [11:0] v;
        {reg_wr, reg_rd, conversion_start_rise, conversion_start_fall, address_load_select} = '0;
        {reg_addr, reg_wdata, chan_addr_in, vin} = '0;
        {strobe_a, strobe_b, address_clear_select, lower_bank_enable, upper_bank_enable, rst} = '1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(acs_pkg::REG_CTRL, acs_pkg::CTRL_RESET);
        rd(acs_pkg::REG_TRIM, 32'h01f4_007d);
        rd(acs_pkg::REG_STATUS, 32'h0);
        rd(8'h10, 32'h0);
        wr(acs_pkg::REG_RESULT, 32'h0000_0abc);
        rd(acs_pkg::REG_RESULT, 32'h0);
        wr(acs_pkg::REG_TRIM, 32'h0fff_00ff);
        rd(acs_pkg::REG_TRIM, 32'h07d0_00d0);
        wr(acs_pkg::REG_TRIM, 32'h0000_0001);
        rd(acs_pkg::REG_TRIM, 32'h012c_007d);
        $display("register test done");
        for (k = 0; k < 4; k++) begin
            v = 12'($random(seed));
            lower_bank_enable <= v[4];
            upper_bank_enable <= v[5];
            step(v[6], v[3:0], 1'b0, 1'b1, v[3:0]);
            cmp_reg({31'h0, lower_bank_route}, {31'h0, v[4] & ~v[3]});
            cmp_reg({31'h0, upper_bank_route}, {31'h0, v[5] & v[3]});
        end
        step(1'b0, 4'hf, 1'b0, 1'b1, 4'hf);
        step(1'b1, 4'h3, 1'b1, 1'b1, 4'h0);
        step(1'b0, 4'h6, 1'b0, 1'b1, 4'h6);
        step(1'b1, 4'h9, 1'b1, 1'b0, 4'h0);
        step(1'b1, 4'hc, 1'b0, 1'b1, 4'hc);
        address_load_select <= 1'b1;
        strobe_b <= 1'b0;
        repeat (6) @(posedge clk);
        strobe_a <= 1'b0;
        repeat (6) @(posedge clk);
        strobe_a <= 1'b1;
        strobe_b <= 1'b1;
        wait_quiet();
        cmp_reg({28'h0, selected_channel}, 32'hd);
        $display("channel test done");
        for (k = 0; k < 5; k++) begin
            v = 12'($random(seed));
            vin <= v;
            wr(acs_pkg::REG_CTRL, k == 4 ? 32'h160 : k == 3 ? 32'h10 : 32'h20 | (k << 3));
            convert(k[0], coded(k, v));
            wait_quiet();
        end
        $display("conversion test done");
        for (k = 0; k < 2; k++) begin
            wr(acs_pkg::REG_CTRL, k ? 32'h24 : 32'h20);
            convert(1'b0, v);
            pulse_strobe(1'b0, k ? 4'h2 : 4'h7, 1'b0, 1'b1);
            cmp_reg({28'h0, selected_channel}, k ? 32'h2 : 32'hd);
            wait_quiet();
            repeat (4) @(posedge clk);
            wait_quiet();
            cmp_reg({28'h0, selected_channel}, k ? 32'h2 : 32'h7);
        end
        wr(acs_pkg::REG_CTRL, 32'h21);
        q_res.push_back(v);
        q_res.push_back(v);
        conversion_start_rise <= 1'b1;
        for (i = 0; i < 5000 && q_res.size() != 0; i++) @(posedge clk);
        conversion_start_rise <= 1'b0;
        cmp_reg(32'(q_res.size()), 32'h0);
        wait_quiet();
        repeat (20) @(posedge clk);
        cmp_reg({27'h0, conversion_active_flag, selected_channel}, 32'h4);
        wr(acs_pkg::REG_CTRL, 32'h22);
        step(1'b0, 4'h9, 1'b0, 1'b1, 4'h5);
        $display("sequencing test done");
        conclude();
    end
endmodule : tb

bind acs_sequencer acs_sequencer_sva u_sva (.clk, .rst, .conversion_start_rise, .conversion_start_fall, .sample_hold,
    .lower_bank_route, .upper_bank_route, .selected_channel, .settle_delay_out, .conversion_active_flag, .dac_code,
    .result_out);
`default_nettype wire
